// ### logic/sbs_pkg.sv
// Shared constants, cycle types and helpers of the pipelined burst memory port
package sbs_pkg;

  // Array organisation
  localparam int ADDR_W = 19;
  localparam int WORDS = 524288;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = 36;
  localparam int BURST_W = 2;

  // Burst step at a new-address load and per advance
  localparam logic [1:0] BURST_STEP_FIRST = 2'h0;
  localparam logic [1:0] BURST_STEP_INC = 2'h1;

  // Reset values of pipeline state
  localparam logic [3:0] STROBE_N_RESET = 4'hf;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h0;

  // Cycle type fixed at a load and inherited by continuation cycles
  typedef enum logic [2:0] {
    SBS_DESELECT = 3'b001,
    SBS_READ = 3'b010,
    SBS_WRITE = 3'b100
  } sbs_cycle_type;

  localparam sbs_cycle_type CYCLE_RESET = SBS_DESELECT;

  // Low address bits of a burst access: interleaved XOR or linear wrap
  function automatic logic [1:0] sbs_burst_low(input logic [1:0] start,
                                               input logic [1:0] step,
                                               input logic interleave);
    if (interleave) begin
      return start ^ step;
    end
    return 2'(start + step);
  endfunction : sbs_burst_low

  // Byte-lane merge: lanes with a low strobe take the new data
  function automatic logic [WORD_W-1:0] sbs_merge(input logic [WORD_W-1:0] old_word,
                                                  input logic [WORD_W-1:0] new_word,
                                                  input logic [LANES-1:0] strobe_n);
    logic [WORD_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (!strobe_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : sbs_merge

endpackage : sbs_pkg

// ### logic/sbs_burst_counter.sv
// Two-bit burst counter, preset at a load and stepped on each advance
`timescale 1ns/1ps
module sbs_burst_counter (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic advance,
  input wire logic [1:0] start,
  input wire logic interleave,
  output logic [1:0] low_bits
);

  logic [1:0] start_q;
  logic [1:0] step_q;

  // Start value taken from the external address, step counts the accesses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_q <= sbs_pkg::BURST_STEP_FIRST;
      step_q <= sbs_pkg::BURST_STEP_FIRST;
    end else if (load) begin
      start_q <= start;
      step_q <= sbs_pkg::BURST_STEP_FIRST;
    end else if (advance) begin
      step_q <= 2'(step_q + sbs_pkg::BURST_STEP_INC);
    end
  end

  // Wraps to the start after four accesses in either order
  assign low_bits = sbs_pkg::sbs_burst_low(start_q, step_q, interleave);

  // A load presets the low bits to the external start value
  property p_preset;
    @(posedge ref_clk) disable iff (!rst_n)
    load |=> low_bits == $past(start);
  endproperty
  a_preset: assert property (p_preset)
    else $error("burst counter not preset by a load");

  // Each advance steps the access count by one
  property p_step;
    @(posedge ref_clk) disable iff (!rst_n)
    advance && !load |=> step_q == 2'($past(step_q) + sbs_pkg::BURST_STEP_INC);
  endproperty
  a_step: assert property (p_step)
    else $error("burst counter did not step on an advance");

  sequence s_fresh_load;
    load;
  endsequence

  sequence s_two_steps;
    (advance && !load)[*2];
  endsequence

  // Both orders reach the start with bit one flipped on the third access
  property p_third_access;
    @(posedge ref_clk) disable iff (!rst_n)
    s_fresh_load ##1 s_two_steps |=> low_bits == (start_q ^ 2'h2);
  endproperty
  a_third_access: assert property (p_third_access)
    else $error("third burst access at the wrong address");

endmodule : sbs_burst_counter

// ### logic/sbs_sram_port.sv
// Pipelined burst static memory: input stage, burst counter, array and output register
// Notes on behaviour
// - Array of 524288 words, 36 bits, four 9-bit byte lanes.
// - Enabled rising edge registers address, data, selects, strobes and burst control.
// - Read data leaves from an output register, not straight from array.
// - Two low address bits preset the burst counter at each selected load.
// - Load/advance low loads an address and starts read, write or deselect.
// - Cycle type set only at a load; continuation cycles inherit it.
// - Load/advance high steps burst counter to next address of access.
// - Read/write select ignored while load/advance is high.
// - Selected only when first low, second high, third low, at loads.
// - Each low lane strobe writes its lane; high lanes keep contents.
// - Captured strobes travel with their access to the later write data.
// - Writes need read/write low and strobes; array write is clocked.
// - Clock enable high: edge ignored, all state holds.
// - Output enable high forces data pins undriven, even in a read.
// - Sleep high enters standby keeping array contents; low means normal.
// - While sleeping, every other input but rst_n is ignored, clock included.
// - Static burst-order input chooses interleaved or linear for all bursts.
// - Burst-order high gives interleaved order, low gives linear order.
// - Bursts of four vary two low bits: XOR or wrapping increment.
// - At a load read/write high reads, low writes; all strobes low full.
// - Deselect and its continuations leave data undriven and use no address.
`timescale 1ns/1ps
module sbs_sram_port #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int WORDS = sbs_pkg::WORDS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic load_or_advance,
  input wire logic read_not_write,
  input wire logic lane0_write_strobe_n,
  input wire logic lane1_write_strobe_n,
  input wire logic lane2_write_strobe_n,
  input wire logic lane3_write_strobe_n,
  input wire logic clock_enable_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_select,
  input wire logic [7:0] lane0_data_in,
  input wire logic [7:0] lane1_data_in,
  input wire logic [7:0] lane2_data_in,
  input wire logic [7:0] lane3_data_in,
  input wire logic lane0_parity_in,
  input wire logic lane1_parity_in,
  input wire logic lane2_parity_in,
  input wire logic lane3_parity_in,
  output logic [7:0] lane0_data_out,
  output logic [7:0] lane1_data_out,
  output logic [7:0] lane2_data_out,
  output logic [7:0] lane3_data_out,
  output logic lane0_parity_out,
  output logic lane1_parity_out,
  output logic lane2_parity_out,
  output logic lane3_parity_out,
  output logic data_oe
);

  localparam int WORD_W = sbs_pkg::WORD_W;
  localparam int LANES = sbs_pkg::LANES;

  // Storage; no reset, contents survive sleep
  logic [WORD_W-1:0] mem [WORDS];

  logic enable;
  logic load;
  logic advance;
  logic selected;
  logic [1:0] burst_low;
  logic [LANES-1:0] strobe_n_in;
  logic [WORD_W-1:0] data_in;
  // Stage one holds the loaded access, stage two feeds the array, stage three the pins
  logic [ADDR_W-3:0] s1_high_q;
  sbs_pkg::sbs_cycle_type s1_cycle_q;
  logic [LANES-1:0] s1_strobe_n_q;
  sbs_pkg::sbs_cycle_type s2_cycle_q;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [LANES-1:0] s2_strobe_n_q;
  logic [WORD_W-1:0] out_q;
  logic read_valid_q;
  // Decoded type of a load, valid only while load is high
  sbs_pkg::sbs_cycle_type load_cycle;

  // Clock enable and sleep both freeze every register; the array simply keeps its words
  assign enable = !clock_enable_n && !sleep_request;

  // Load/advance low loads a new address, high steps the burst of the current access
  assign load = enable && !load_or_advance;
  assign advance = enable && load_or_advance;

  // Selected only for the one select pattern; the result matters only at a load
  assign selected = !select_first_n && select_second && !select_third_n;

  // Lane strobes gathered lowest lane first
  assign strobe_n_in = {lane3_write_strobe_n, lane2_write_strobe_n,
                        lane1_write_strobe_n, lane0_write_strobe_n};

  // Each 9-bit lane is eight data bits with the parity bit on top
  assign data_in = {lane3_parity_in, lane3_data_in, lane2_parity_in, lane2_data_in,
                    lane1_parity_in, lane1_data_in, lane0_parity_in, lane0_data_in};

  // Cycle type decode at a load; reads and writes differ only in read_not_write
  always_comb begin
    load_cycle = sbs_pkg::SBS_DESELECT;
    case ({selected, read_not_write})
      2'b11: begin
        load_cycle = sbs_pkg::SBS_READ;
      end
      2'b10: begin
        load_cycle = sbs_pkg::SBS_WRITE;
      end
      default: begin
        load_cycle = sbs_pkg::SBS_DESELECT;
      end
    endcase
  end

  // Burst counter: preset at a selected load, stepped on each advance
  sbs_burst_counter burst_ctr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load && selected),
    .advance(advance),
    .start(word_address[1:0]),
    .interleave(burst_order_select),
    .low_bits(burst_low)
  );

  // Stage one: cycle type, fixed at a load and inherited by every advance
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_cycle_q <= sbs_pkg::CYCLE_RESET;
    end else if (load) begin
      s1_cycle_q <= load_cycle;
    end
  end

  // Stage one: upper address bits; a deselect leaves them alone as it uses no address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_high_q <= (ADDR_W-2)'(sbs_pkg::ADDR_RESET >> 2);
    end else if (load && selected) begin
      s1_high_q <= word_address[ADDR_W-1:2];
    end
  end

  // Stage one: lane strobes taken with their own address on every cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_strobe_n_q <= sbs_pkg::STROBE_N_RESET;
    end else if (enable) begin
      s1_strobe_n_q <= strobe_n_in;
    end
  end

  // Stage two: the access moves on with its type one edge after its address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s2_cycle_q <= sbs_pkg::CYCLE_RESET;
    end else if (enable) begin
      s2_cycle_q <= s1_cycle_q;
    end
  end

  // Stage two: full word address and the strobes that belong to it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s2_addr_q <= ADDR_W'(sbs_pkg::ADDR_RESET);
      s2_strobe_n_q <= sbs_pkg::STROBE_N_RESET;
    end else if (enable) begin
      s2_addr_q <= {s1_high_q, burst_low};
      s2_strobe_n_q <= s1_strobe_n_q;
    end
  end

  // Stage three: marks a cycle in which the output register holds read data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      read_valid_q <= 1'b0;
    end else if (enable) begin
      read_valid_q <= (s2_cycle_q == sbs_pkg::SBS_READ);
    end
  end

  // Stage three: output register; reads never leave straight from the array, so the
  // array access time stays off the pin timing path
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_q <= '0;
    end else if (enable && s2_cycle_q == sbs_pkg::SBS_READ) begin
      out_q <= mem[s2_addr_q];
    end
  end

  // Stage three: write data is taken two edges after its address, so the bus turns
  // around with no idle cycle; lanes with a high strobe keep their old contents
  always_ff @(posedge ref_clk) begin
    if (rst_n && enable && s2_cycle_q == sbs_pkg::SBS_WRITE) begin
      mem[s2_addr_q] <= sbs_pkg::sbs_merge(mem[s2_addr_q], data_in,
                                           s2_strobe_n_q);
    end
  end

  // Drivers on only for read data with output enable low; a pending write takes the bus,
  // which trades the overlapping read word for freedom from contention
  assign data_oe = read_valid_q && !output_enable_n && !sleep_request
                   && (s2_cycle_q != sbs_pkg::SBS_WRITE);

  // Output lanes straight from the output register
  assign lane0_data_out = out_q[7:0];
  assign lane0_parity_out = out_q[8];
  assign lane1_data_out = out_q[16:9];
  assign lane1_parity_out = out_q[17];
  assign lane2_data_out = out_q[25:18];
  assign lane2_parity_out = out_q[26];
  assign lane3_data_out = out_q[34:27];
  assign lane3_parity_out = out_q[35];

  // Checks of the pipeline against the rules it carries out

  // A selected read load
  sequence s_read_load;
    load && selected && read_not_write;
  endsequence

  // Two enabled edges in a row carry an access through stages two and three
  sequence s_two_enabled;
    enable ##1 enable;
  endsequence

  property p_read_latency;
    @(posedge ref_clk) disable iff (!rst_n)
    s_read_load ##1 s_two_enabled |=> read_valid_q;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read not presented two enabled edges after its load");

  // A refused edge changes no pipeline state
  property p_stall_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !enable |=> $stable(s1_cycle_q) && $stable(s2_cycle_q) && $stable(read_valid_q)
      && $stable(out_q) && $stable(s2_addr_q);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("pipeline state moved on a refused edge");

  // Advances keep the type chosen at the load, whatever read_not_write does
  property p_advance_type;
    @(posedge ref_clk) disable iff (!rst_n)
    advance |=> $stable(s1_cycle_q);
  endproperty
  a_advance_type: assert property (p_advance_type)
    else $error("cycle type changed without a load");

  // A load with any select off becomes a deselect
  property p_deselect_load;
    @(posedge ref_clk) disable iff (!rst_n)
    load && !selected |=> s1_cycle_q == sbs_pkg::SBS_DESELECT;
  endproperty
  a_deselect_load: assert property (p_deselect_load)
    else $error("unselected load did not deselect");

  // A selected load with read_not_write low starts a write
  property p_write_load;
    @(posedge ref_clk) disable iff (!rst_n)
    load && selected && !read_not_write |=> s1_cycle_q == sbs_pkg::SBS_WRITE;
  endproperty
  a_write_load: assert property (p_write_load)
    else $error("selected write load did not start a write");

  // Only a read in stage two may mark output data
  property p_quiet_unless_read;
    @(posedge ref_clk) disable iff (!rst_n)
    enable && s2_cycle_q != sbs_pkg::SBS_READ |=> !read_valid_q;
  endproperty
  a_quiet_unless_read: assert property (p_quiet_unless_read)
    else $error("output marked valid without a read");

  // Output enable high or sleep forces the drivers off at once
  property p_drivers_off;
    @(posedge ref_clk) disable iff (!rst_n)
    output_enable_n || sleep_request |-> !data_oe;
  endproperty
  a_drivers_off: assert property (p_drivers_off)
    else $error("data driven with output enable high");

  // Never drive while write data is due from the controller
  property p_write_turnaround;
    @(posedge ref_clk) disable iff (!rst_n)
    s2_cycle_q == sbs_pkg::SBS_WRITE |-> !data_oe;
  endproperty
  a_write_turnaround: assert property (p_write_turnaround)
    else $error("data driven while write data is due");

endmodule : sbs_sram_port

// ### tb/sbs_ctrl_model.sv
// Memory controller model that supplies write data on the shared data lanes
`timescale 1ns/1ps
module sbs_ctrl_model (
  input wire logic ref_clk,
  input wire logic wv,
  input wire logic [35:0] wd,
  output logic [35:0] bus
);
  logic [36:0] slot_q = '0;
  logic [35:0] bus_q = '0;
  assign bus = bus_q;
  // Data is launched one edge late so it stands at the capture edge; idle bus toggles
  always @(posedge ref_clk) begin
    slot_q <= {wv, wd};
    bus_q <= slot_q[36] ? slot_q[35:0] : ~bus_q;
  end
endmodule : sbs_ctrl_model

// ### tb/test_sync_pipelined_burst_sram_port.sv
// Self-checking bench of the pipelined burst memory port
`timescale 1ns/1ps
module test_sync_pipelined_burst_sram_port;
  logic ref_clk, rst_n, select_first_n, select_second, select_third_n, load_or_advance;
  logic read_not_write, output_enable_n, burst_order_select, data_oe, wv;
  logic clock_enable_n, sleep_request;
  logic [18:0] word_address;
  logic [3:0] bw;
  logic [35:0] wd, b, q, r;
  logic [35:0] rnd = 36'h48;
  logic [35:0] mem [int];
  logic [35:0] exp_q [$];
  int errors = 0;
  int check_count = 0;
  sbs_ctrl_model ctrl (.ref_clk, .wv, .wd, .bus(b));
  sbs_sram_port uut (.ref_clk, .rst_n, .word_address, .select_first_n, .select_second,
    .select_third_n, .load_or_advance, .read_not_write, .clock_enable_n,
    .output_enable_n, .sleep_request, .burst_order_select, .data_oe,
    .lane0_write_strobe_n(bw[0]), .lane1_write_strobe_n(bw[1]),
    .lane2_write_strobe_n(bw[2]), .lane3_write_strobe_n(bw[3]),
    .lane0_data_in(b[7:0]), .lane1_data_in(b[16:9]), .lane2_data_in(b[25:18]),
    .lane3_data_in(b[34:27]), .lane0_parity_in(b[8]), .lane1_parity_in(b[17]),
    .lane2_parity_in(b[26]), .lane3_parity_in(b[35]),
    .lane0_data_out(q[7:0]), .lane1_data_out(q[16:9]), .lane2_data_out(q[25:18]),
    .lane3_data_out(q[34:27]), .lane0_parity_out(q[8]), .lane1_parity_out(q[17]),
    .lane2_parity_out(q[26]), .lane3_parity_out(q[35]));
  function automatic logic [35:0] lf(input logic [35:0] x);
    return {x[34:0], x[35] ^ x[24]};
  endfunction : lf
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // One load and three advances; advance cycles carry junk that must be ignored
  task automatic burst(input logic rw, input logic [18:0] a, input logic [3:0] s,
                       input logic sel);
    logic [18:0] x;
    logic [35:0] m;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      rnd = lf(rnd);
      x = {a[18:2], burst_order_select ? a[1:0] ^ 2'(i) : 2'(a[1:0] + 2'(i))};
      load_or_advance <= (i != 0);
      read_not_write <= i ? rnd[3] : rw;
      word_address <= i ? rnd[22:4] : a;
      {select_first_n, select_second, select_third_n} <= i ? rnd[2:0] :
        sel ? 3'b010 : 3'b010 ^ (3'h1 << rnd[1:0] % 3);
      bw <= s;
      wv <= sel & !rw;
      wd <= rnd;
      m = mem.exists(x) ? mem[x] : '0;
      if (sel && !rw) begin
        for (int j = 0; j < 4; j++) if (!s[j]) m[j*9 +: 9] = rnd[j*9 +: 9];
        mem[x] = m;
      end else if (sel && !output_enable_n) exp_q.push_back(m);
    end
  endtask : burst
  // Each read word is driven for one cycle; oe off or deselect must leave it undriven
  always @(negedge ref_clk) if (rst_n && data_oe !== 1'b0) begin
    r = exp_q.size() ? exp_q.pop_front() : 'x;
    check_count++;
    if (q !== r) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, q, r);
    end
  end
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    {rst_n, select_first_n, select_second, select_third_n, wv} = 5'b01000;
    {load_or_advance, read_not_write, output_enable_n, burst_order_select} = 4'h0;
    {clock_enable_n, sleep_request} = 2'h0;
    word_address = '0;
    bw = 4'hf;
    wd = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    for (int o = 0; o < 2; o++) begin
      burst_order_select <= !o[0];
      burst(0, 19'h1234d + 19'(o), 4'h0, 1);
      burst(0, 19'h1234d + 19'(o), 4'ha, 1);
      burst(1, 19'h1234f, 4'hf, 1);
      burst(1, 19'h1234d, 4'hf, 0);
    end
    output_enable_n <= 1;
    burst(1, 19'h1234c, 4'hf, 1);
    burst(1, 19'h0, 4'hf, 0);
    output_enable_n <= 0;
    burst(1, 19'h1234e, 4'hf, 1);
    burst(1, 19'h0, 4'hf, 0);
    // Stall then sleep while a selected full write is offered; it must not land
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      clock_enable_n <= (k < 4);
      sleep_request <= (k >= 4 && k < 7);
      {select_first_n, select_second, select_third_n} <= (k < 7) ? 3'b010 : 3'b110;
      {load_or_advance, read_not_write, bw} <= 6'h0;
      word_address <= 19'h1234e;
    end
    burst(1, 19'h1234e, 4'hf, 1);
    burst(1, 19'h0, 4'hf, 0);
    if (exp_q.size() != 0) errors++;
    give_verdict();
  end
endmodule : test_sync_pipelined_burst_sram_port
